/* File: include/fcache_aux_defines.svh */
// Register map, field positions, reset values and codes of the aux control
`ifndef FCACHE_AUX_DEFINES_SVH
`define FCACHE_AUX_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FC_OFS_TIMING 8'h04
`define FC_OFS_EXIT 8'h08
`define FC_OFS_STATS 8'h0c
`define FC_OFS_HITS 8'h10
`define FC_OFS_MISSES 8'h14
`define FC_OFS_SHIFT 8'h18
`define FC_OFS_TARGET 8'h1c
`define FC_OFS_LATENCY 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FC_BIT_CAPT_EDGE 4
`define FC_BIT_CLK_PHA 7
`define FC_BIT_CLK_POL 8
`define FC_BIT_EXIT_DONE 0
`define FC_BIT_OFFSET_EN 3
`define FC_BIT_MATCH_EN 2
`define FC_BIT_MISS_EN 1
`define FC_BIT_HIT_EN 0
`define FC_BIT_ZERO_WAIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FC_RST_CAPT_EDGE 1'b1
`define FC_RST_CLK_POL 1'b0
`define FC_RST_CLK_PHA 1'b0
`define FC_RST_STATS 4'h0
`define FC_RST_ZERO_WAIT 1'b1

// ----------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------
`define FC_KIND_EXIT_A 4'hc
`define FC_KIND_EXIT_B 4'hd
`define FC_RESP_OKAY 2'h0
`define FC_RESP_SLVERR 2'h2
`define FC_HIT_EXTRA_WAIT 1'b1

`endif

/* File: include/fcache_aux_pkg.sv */
// State types of the flash cache aux control
package fcache_aux_pkg;

    // ----------------------------------------------------------------
    // Main block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic exit_flag;
        logic [3:0] stats_cfg;
        logic [31:0] hit_cnt;
        logic [31:0] miss_cnt;
        logic [31:0] base_shift;
        logic [31:0] target;
        logic zero_wait;
        logic capt_edge;
        logic clk_pol;
        logic clk_pha;
        logic [31:0] mapped_addr;
        logic slow_pending;
        logic hit_rd_done;
        logic sclk_idle;
    } ctrl_state_t;

    // ----------------------------------------------------------------
    // Link capture state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] data_sync;
        logic cap_valid;
        logic cap_bit;
    } link_state_t;

endpackage : fcache_aux_pkg

/* File: core/link_capture.sv */
// Serial input capture on the selected serial clock edge
`timescale 1ns/1ps
`include "fcache_aux_defines.svh"

module link_capture (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk_in,
    input wire logic sdata_in,
    input wire logic capture_rise,
    output logic cap_valid,
    output logic cap_bit
);

    fcache_aux_pkg::link_state_t s_r;
    fcache_aux_pkg::link_state_t s_nxt;
    logic rise_seen;
    logic fall_seen;

    // ----------------------------------------------------------------
    // Synchronise, find edges, sample
    // ----------------------------------------------------------------
    assign rise_seen = s_r.sclk_sync[1] & ~s_r.sclk_sync[2];
    assign fall_seen = ~s_r.sclk_sync[1] & s_r.sclk_sync[2];

    always_comb begin
        s_nxt = s_r;
        s_nxt.sclk_sync = {s_r.sclk_sync[1:0], sclk_in};
        s_nxt.data_sync = {s_r.data_sync[0], sdata_in};
        s_nxt.cap_valid = capture_rise ? rise_seen : fall_seen;
        if (s_nxt.cap_valid) begin
            s_nxt.cap_bit = s_r.data_sync[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cap_valid = s_r.cap_valid;
    assign cap_bit = s_r.cap_bit;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_edge_pick;
        @(posedge aclk) disable iff (!aresetn)
        (capture_rise && rise_seen) || (!capture_rise && fall_seen)
        |=> cap_valid && cap_bit == $past(s_r.data_sync[1]);
    endproperty
    a_edge_pick: assert property (p_edge_pick)
        else $error("capture missed the selected edge");

    property p_no_wrong_edge;
        @(posedge aclk) disable iff (!aresetn)
        (capture_rise && fall_seen) || (!capture_rise && rise_seen)
        |=> !cap_valid;
    endproperty
    a_no_wrong_edge: assert property (p_no_wrong_edge)
        else $error("capture on the wrong edge");

endmodule : link_capture

/* File: core/flash_cache_aux_control.sv */
// Flash cache aux control: capture edge, exit flag, offset, stats, wait
//
// How it works
// - Capture-edge select at bit 4, read-write, resets to one.
// - Select clear: rising edge when polarity equals phase, else falling.
// - Select set, polarity 0: falling for phase 0, rising for phase 1.
// - Exit flag bit 0 sets after kind 0xc or 0xd, clears on write-one.
// - Offset enable bit 3 adds the offset register to every flash access.
// - Match and miss enables set: count only misses to the target address.
// - Miss enable bit 1 counts misses in a 32-bit readable counter.
// - Hit enable bit 0 counts hits in a 32-bit readable counter.
// - Any write to a hit or miss counter clears it.
// - Zero-wait set: hit read takes 2 cycles, else 3; resets to one.
// - Polarity zero idles the serial clock low, one idles it high.
`timescale 1ns/1ps
`include "fcache_aux_defines.svh"

module flash_cache_aux_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic lookup_valid,
    input wire logic lookup_hit,
    input wire logic [31:0] lookup_addr,
    input wire logic xfer_done,
    input wire logic [3:0] xfer_kind,
    input wire logic [31:0] access_addr,
    output logic [31:0] mapped_addr,
    input wire logic hit_rd_req,
    output logic hit_rd_done,
    output logic sclk_idle_level,
    input wire logic sclk_in,
    input wire logic sdata_in,
    output logic cap_valid,
    output logic cap_bit
);

    fcache_aux_pkg::ctrl_state_t s_r;
    fcache_aux_pkg::ctrl_state_t s_nxt;
    logic wr_fire;
    logic rd_fire;
    logic hit_ev;
    logic miss_ev;
    logic exit_ev;
    logic capture_rise;
    logic wr_hits;
    logic wr_misses;
    logic wr_exit;

    // ----------------------------------------------------------------
    // Byte-lane merge
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ----------------------------------------------------------------
    // Events and decode
    // ----------------------------------------------------------------
    assign wr_fire = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
    assign rd_fire = arvalid & s_r.arready;
    assign wr_hits = wr_fire & (s_r.aw_addr == `FC_OFS_HITS);
    assign wr_misses = wr_fire & (s_r.aw_addr == `FC_OFS_MISSES);
    assign wr_exit = wr_fire & (s_r.aw_addr == `FC_OFS_EXIT)
        & s_r.w_strb[0] & s_r.w_data[`FC_BIT_EXIT_DONE];
    assign exit_ev = xfer_done & ((xfer_kind == `FC_KIND_EXIT_A)
        | (xfer_kind == `FC_KIND_EXIT_B));
    assign hit_ev = lookup_valid & lookup_hit
        & s_r.stats_cfg[`FC_BIT_HIT_EN];
    assign miss_ev = lookup_valid & ~lookup_hit
        & s_r.stats_cfg[`FC_BIT_MISS_EN]
        & (~s_r.stats_cfg[`FC_BIT_MATCH_EN]
           | (lookup_addr == s_r.target));
    assign capture_rise = (s_r.clk_pol == s_r.clk_pha)
        ^ s_r.capt_edge;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Write address and data, taken in either order
        if (awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `FC_RESP_OKAY;
            unique case (s_r.aw_addr)
                `FC_OFS_TIMING: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.capt_edge =
                            s_r.w_data[`FC_BIT_CAPT_EDGE];
                        s_nxt.clk_pha = s_r.w_data[`FC_BIT_CLK_PHA];
                    end
                    if (s_r.w_strb[1]) begin
                        s_nxt.clk_pol = s_r.w_data[`FC_BIT_CLK_POL];
                    end
                end
                `FC_OFS_EXIT: ;
                `FC_OFS_STATS: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.stats_cfg = s_r.w_data[3:0];
                    end
                end
                `FC_OFS_HITS: ;
                `FC_OFS_MISSES: ;
                `FC_OFS_SHIFT: begin
                    s_nxt.base_shift = merge(s_r.base_shift, s_r.w_data,
                                             s_r.w_strb);
                end
                `FC_OFS_TARGET: begin
                    s_nxt.target = merge(s_r.target, s_r.w_data,
                                         s_r.w_strb);
                end
                `FC_OFS_LATENCY: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.zero_wait =
                            s_r.w_data[`FC_BIT_ZERO_WAIT];
                    end
                end
                default: begin
                    s_nxt.bresp = `FC_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
        s_nxt.wready = ~s_nxt.w_have & ~s_nxt.bvalid;
        // Read channel
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_fire) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `FC_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            unique case (araddr)
                `FC_OFS_TIMING: begin
                    s_nxt.rdata[`FC_BIT_CAPT_EDGE] = s_r.capt_edge;
                    s_nxt.rdata[`FC_BIT_CLK_PHA] = s_r.clk_pha;
                    s_nxt.rdata[`FC_BIT_CLK_POL] = s_r.clk_pol;
                end
                `FC_OFS_EXIT: begin
                    s_nxt.rdata[`FC_BIT_EXIT_DONE] = s_r.exit_flag;
                end
                `FC_OFS_STATS: s_nxt.rdata[3:0] = s_r.stats_cfg;
                `FC_OFS_HITS: s_nxt.rdata = s_r.hit_cnt;
                `FC_OFS_MISSES: s_nxt.rdata = s_r.miss_cnt;
                `FC_OFS_SHIFT: s_nxt.rdata = s_r.base_shift;
                `FC_OFS_TARGET: s_nxt.rdata = s_r.target;
                `FC_OFS_LATENCY: begin
                    s_nxt.rdata[`FC_BIT_ZERO_WAIT] = s_r.zero_wait;
                end
                default: begin
                    s_nxt.rresp = `FC_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.arready = ~s_nxt.rvalid;
        // Exit flag, a new completion wins over the clear
        if (exit_ev) begin
            s_nxt.exit_flag = 1'b1;
        end else if (wr_exit) begin
            s_nxt.exit_flag = 1'b0;
        end
        // Counters, a clearing write keeps a same-cycle event
        if (wr_hits) begin
            s_nxt.hit_cnt = {31'h0000_0000, hit_ev};
        end else if (hit_ev) begin
            s_nxt.hit_cnt = s_r.hit_cnt + 32'h0000_0001;
        end
        if (wr_misses) begin
            s_nxt.miss_cnt = {31'h0000_0000, miss_ev};
        end else if (miss_ev) begin
            s_nxt.miss_cnt = s_r.miss_cnt + 32'h0000_0001;
        end
        // Offset applied to each access
        if (s_r.stats_cfg[`FC_BIT_OFFSET_EN]) begin
            s_nxt.mapped_addr = access_addr + s_r.base_shift;
        end else begin
            s_nxt.mapped_addr = access_addr;
        end
        // Hit read latency
        s_nxt.hit_rd_done = s_r.slow_pending
            | (hit_rd_req & s_r.zero_wait);
        if (s_r.slow_pending) begin
            s_nxt.slow_pending = 1'b0;
        end else if (hit_rd_req && !s_r.zero_wait) begin
            s_nxt.slow_pending = `FC_HIT_EXTRA_WAIT;
        end
        s_nxt.sclk_idle = s_r.clk_pol;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.capt_edge <= `FC_RST_CAPT_EDGE;
            s_r.clk_pol <= `FC_RST_CLK_POL;
            s_r.clk_pha <= `FC_RST_CLK_PHA;
            s_r.stats_cfg <= `FC_RST_STATS;
            s_r.zero_wait <= `FC_RST_ZERO_WAIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Serial capture
    // ----------------------------------------------------------------
    link_capture u_capture (
        .aclk(aclk),
        .aresetn(aresetn),
        .sclk_in(sclk_in),
        .sdata_in(sdata_in),
        .capture_rise(capture_rise),
        .cap_valid(cap_valid),
        .cap_bit(cap_bit)
    );

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign mapped_addr = s_r.mapped_addr;
    assign hit_rd_done = s_r.hit_rd_done;
    assign sclk_idle_level = s_r.sclk_idle;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_exit_set;
        exit_ev |=> s_r.exit_flag;
    endproperty
    a_exit_set: assert property (p_exit_set)
        else $error("exit flag not set after exit command");

    property p_exit_sticky;
        s_r.exit_flag && !wr_exit |=> s_r.exit_flag;
    endproperty
    a_exit_sticky: assert property (p_exit_sticky)
        else $error("exit flag dropped without a clear");

    property p_hit_step;
        hit_ev && !wr_hits |=> s_r.hit_cnt == $past(s_r.hit_cnt) + 1;
    endproperty
    a_hit_step: assert property (p_hit_step)
        else $error("hit counter did not step by one");

    property p_hit_hold;
        !s_r.stats_cfg[`FC_BIT_HIT_EN] && !wr_hits |=> $stable(s_r.hit_cnt);
    endproperty
    a_hit_hold: assert property (p_hit_hold)
        else $error("hit counter moved while disabled");

    property p_miss_filter;
        lookup_valid && !lookup_hit && s_r.stats_cfg[`FC_BIT_MATCH_EN]
        && lookup_addr != s_r.target && !wr_misses
        |=> $stable(s_r.miss_cnt);
    endproperty
    a_miss_filter: assert property (p_miss_filter)
        else $error("miss to another address was counted");

    property p_counter_clear;
        wr_hits && !hit_ev |=> s_r.hit_cnt == 32'h0000_0000;
    endproperty
    a_counter_clear: assert property (p_counter_clear)
        else $error("hit counter not cleared by write");

    property p_fast_hit;
        hit_rd_req && !s_r.slow_pending && s_r.zero_wait |=> hit_rd_done;
    endproperty
    a_fast_hit: assert property (p_fast_hit)
        else $error("zero-wait hit read not done in two cycles");

    property p_slow_hit;
        hit_rd_req && !s_r.slow_pending && !s_r.zero_wait
        |=> !hit_rd_done ##1 hit_rd_done;
    endproperty
    a_slow_hit: assert property (p_slow_hit)
        else $error("waited hit read not done in three cycles");

    property p_offset;
        s_r.stats_cfg[`FC_BIT_OFFSET_EN]
        |=> mapped_addr == $past(access_addr) + $past(s_r.base_shift);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not applied to access");

    property p_idle_level;
        ##1 sclk_idle_level == $past(s_r.clk_pol);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("idle level does not follow polarity");

endmodule : flash_cache_aux_control

/* File: bench/serial_flash_model.sv */
// Serial flash stand-in that shifts a frame out on its own link clock
`timescale 1ns/1ps

module serial_flash_model (
    input wire logic frame_go,
    input wire logic idle_level,
    input wire logic [15:0] frame_bits,
    output logic sclk,
    output logic sdata,
    output logic frame_busy
);
    logic in_frame = 1'h0;
    logic sclk_f = 1'h0;

    // Link clock stands at the idle level outside frames
    assign sclk = in_frame ? sclk_f : idle_level;
    assign frame_busy = in_frame;

    // Data moves midway between edges: leading and trailing edges differ
    initial begin
        sdata = 1'h0;
        forever begin
            @(posedge frame_go);
            sclk_f = idle_level;
            in_frame = 1'h1;
            for (int i = 15; i > 0; i -= 2) begin
                sdata = frame_bits[i];
                #12 sclk_f = ~idle_level;
                #12 sdata = frame_bits[i-1];
                #12 sclk_f = idle_level;
                #12;
            end
            in_frame = 1'h0;
            // Released line shows the inverse of the last bit
            sdata = ~sdata;
        end
    end
endmodule : serial_flash_model

/* File: bench/flash_cache_aux_control_bench.sv */
// Self-checking bench of the flash cache aux control
`timescale 1ns/1ps
`include "fcache_aux_defines.svh"

module flash_cache_aux_control_bench;
    // ----------------------------------------------------------------
    // Signals and reference model state
    // ----------------------------------------------------------------
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, mapped_addr, rd_v, sh_v, ad_v;
    logic lookup_valid = 1'h0, lookup_hit = 1'h0, xfer_done = 1'h0;
    logic hit_rd_req = 1'h0, frame_go = 1'h0;
    logic [3:0] xfer_kind = 4'h0;
    logic [31:0] lookup_addr = 32'h0, access_addr = 32'h0;
    logic hit_rd_done, sclk_idle_level, sclk_in, sdata_in;
    logic cap_valid, cap_bit, frame_busy, rise, lead;
    logic [15:0] frame_bits = 16'h0;
    logic [31:0] seed = 32'hca53;
    logic [31:0] tgt_m = 32'h0;
    logic [3:0] cfg_m = 4'h0;
    logic cap_q[$];
    int err_total = 0, cmp_count = 0, cyc = 0, hit_m = 0, miss_m = 0;
    logic [7:0] ofs[8] = '{`FC_OFS_TIMING, `FC_OFS_EXIT, `FC_OFS_STATS,
        `FC_OFS_HITS, `FC_OFS_MISSES, `FC_OFS_SHIFT, `FC_OFS_TARGET,
        `FC_OFS_LATENCY};
    logic [31:0] rstv[8] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h1};
    logic [7:0] rw_ofs[4] = '{`FC_OFS_TIMING, `FC_OFS_STATS, `FC_OFS_SHIFT,
        `FC_OFS_LATENCY};
    logic [31:0] rw_exp[4] = '{32'h180, 32'hf, 32'hffffffef, 32'h1};
    logic [2:0] lk[5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1};

    flash_cache_aux_control dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .lookup_valid(lookup_valid), .lookup_hit(lookup_hit),
        .lookup_addr(lookup_addr), .xfer_done(xfer_done),
        .xfer_kind(xfer_kind), .access_addr(access_addr),
        .mapped_addr(mapped_addr), .hit_rd_req(hit_rd_req),
        .hit_rd_done(hit_rd_done), .sclk_idle_level(sclk_idle_level),
        .sclk_in(sclk_in), .sdata_in(sdata_in), .cap_valid(cap_valid),
        .cap_bit(cap_bit)
    );

    serial_flash_model flash_u (
        .frame_go(frame_go), .idle_level(sclk_idle_level),
        .frame_bits(frame_bits), .sclk(sclk_in), .sdata(sdata_in),
        .frame_busy(frame_busy)
    );

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (cap_valid === 1'h1) cap_q.push_back(cap_bit);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_resp(input string nm, input logic [1:0] e);
        chk(nm, {30'h0, e}, {30'h0, rsp});
    endtask : chk_resp

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'h1) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready === 1'h1) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge aclk);
        rsp = bresp;
        bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string nm);
        axi_rd(a);
        chk(nm, e, rd_v);
    endtask : rd_chk

    task automatic set_cfg(input logic [3:0] v);
        axi_wr(`FC_OFS_STATS, {28'h0, v});
        cfg_m = v;
    endtask : set_cfg

    task automatic lookups(input int n);
        logic [31:0] ad;
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            seed = lfsr(seed);
            ad = seed[2] ? tgt_m : seed;
            lookup_valid <= seed[0];
            lookup_hit <= seed[1];
            lookup_addr <= ad;
            if (seed[0] && seed[1] && cfg_m[0]) hit_m++;
            if (seed[0] && !seed[1] && cfg_m[1] && (!cfg_m[2] || ad == tgt_m))
                miss_m++;
        end
        @(posedge aclk);
        lookup_valid <= 1'h0;
    endtask : lookups

    task automatic hit_rd(input logic [31:0] e);
        int n;
        @(posedge aclk);
        hit_rd_req <= 1'h1;
        @(posedge aclk);
        hit_rd_req <= 1'h0;
        n = 2;
        @(posedge aclk);
        while (hit_rd_done !== 1'h1 && n < 8) begin
            @(posedge aclk);
            n++;
        end
        chk("hit read cycles", e, 32'(n));
    endtask : hit_rd

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 8; i++) rd_chk(ofs[i], rstv[i], "reset");
        axi_rd(8'h40);
        chk_resp("unmapped read", `FC_RESP_SLVERR);
        axi_wr(8'h40, 32'hffffffff);
        chk_resp("unmapped write", `FC_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            axi_wr(rw_ofs[i], 32'hffffffef);
            rd_chk(rw_ofs[i], rw_exp[i], "readback");
        end
        set_cfg(4'h0);
        hit_rd(32'h2);
        axi_wr(`FC_OFS_LATENCY, 32'h0);
        hit_rd(32'h3);
        for (int k = 0; k < 16; k++) begin
            @(posedge aclk);
            xfer_done <= 1'h1;
            xfer_kind <= k[3:0];
            @(posedge aclk);
            xfer_done <= 1'h0;
            if (k[3:0] == `FC_KIND_EXIT_A || k[3:0] == `FC_KIND_EXIT_B) begin
                do axi_rd(`FC_OFS_EXIT); while (rd_v[0] !== 1'h1);
                axi_wr(`FC_OFS_EXIT, 32'h0);
                rd_chk(`FC_OFS_EXIT, 32'h1, "exit sticky");
                axi_wr(`FC_OFS_EXIT, 32'h1);
            end
            rd_chk(`FC_OFS_EXIT, 32'h0, "exit flag");
        end
        set_cfg(4'h3);
        axi_wr(`FC_OFS_MISSES, seed);
        lookups(200);
        rd_chk(`FC_OFS_HITS, 32'(hit_m), "hits");
        rd_chk(`FC_OFS_MISSES, 32'(miss_m), "misses");
        axi_wr(`FC_OFS_HITS, ~seed);
        hit_m = 0;
        rd_chk(`FC_OFS_HITS, 32'h0, "hits cleared");
        rd_chk(`FC_OFS_MISSES, 32'(miss_m), "misses kept");
        set_cfg(4'h0);
        lookups(60);
        rd_chk(`FC_OFS_MISSES, 32'(miss_m), "misses held");
        seed = lfsr(seed);
        tgt_m = seed;
        axi_wr(`FC_OFS_TARGET, tgt_m);
        rd_chk(`FC_OFS_TARGET, tgt_m, "target");
        axi_wr(`FC_OFS_MISSES, seed);
        miss_m = 0;
        set_cfg(4'h6);
        lookups(200);
        rd_chk(`FC_OFS_HITS, 32'(hit_m), "hits held");
        rd_chk(`FC_OFS_MISSES, 32'(miss_m), "matched misses");
        seed = lfsr(seed);
        sh_v = seed;
        ad_v = ~lfsr(seed);
        axi_wr(`FC_OFS_SHIFT, sh_v);
        set_cfg(4'h8);
        access_addr <= ad_v;
        repeat (3) @(posedge aclk);
        chk("mapped with offset", ad_v + sh_v, mapped_addr);
        set_cfg(4'h0);
        repeat (3) @(posedge aclk);
        chk("mapped plain", ad_v, mapped_addr);
        for (int j = 0; j < 5; j++) begin
            axi_wr(`FC_OFS_TIMING,
                   {23'h0, lk[j][2], lk[j][1], 2'h0, lk[j][0], 4'h0});
            repeat (20) @(posedge aclk);
            chk("idle level", 32'(lk[j][2]), 32'(sclk_idle_level));
            cap_q.delete();
            seed = lfsr(seed);
            frame_bits <= seed[15:0];
            frame_go <= 1'h1;
            @(posedge aclk);
            frame_go <= 1'h0;
            do @(posedge aclk); while (frame_busy);
            repeat (10) @(posedge aclk);
            rise = (lk[j][2] == lk[j][1]) ^ lk[j][0];
            lead = (rise == !lk[j][2]);
            chk("capture count", 32'h8, 32'(cap_q.size()));
            for (int i = 0; i < 8; i++)
                chk("captured bit", {31'h0, frame_bits[15-2*i-(lead?0:1)]},
                    {31'h0, cap_q[i]});
        end
        test_done();
    end
endmodule : flash_cache_aux_control_bench
